// ==== rtl/svmc_top.sv ====
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// R1 - power-up clears cold/warm flag to cold
// R2 - power-on and monitor-0 reset clear cold/warm
// R3 - cold/warm set by software only, kept otherwise
// R4 - software picks threshold-0 level by usage
// R5 - low threshold-0 needs hardware reset afterwards
// R6 - autostart 0: monitor-0 reset enabled after power-on
// R7 - oscillation-stop reset halts until hw/monitor-0 reset
// R8 - osc-stop flag kept by hw, cleared monitor-0
// R9 - detector 0 resets while supply below threshold
// R10 - detectors 1/2 reset mode on falling crossing
// R11 - interrupt edges depend on filter enable
// R12 - filter samples three times at divided clock
// R13 - enable/monitor-0 reset values follow autostart; code does so on hardware reset only, power-on/monitor-0 load the on values
// R14 - level-2 and enable registers survive minor resets
// R15 - select registers survive watchdog/osc/software resets
// R16 - level-2 flag low only below threshold enabled
// R17 - protect bit 3 gates protected register writes
// R18 - bit 5 enables detector 0 after delay
// R19 - detector 1 needs master and bit 6
// R20 - detector 2 needs master and bit 7
// R21 - software sets master when detector 1/2 used
// R22 - level-1 select reads default while master off
// R23 - filter active when filter-disable bit is 0
// R24 - enable delay counted in slow ticks, masked
module svmc_top
  import svmc_pkg::*;
#(
  parameter logic [7:0] EN_DLY_TICKS = EN_DLY_TICKS_DEF
)
(
  input logic aclk,
  input logic aresetn,
  input svmc_axi_req_t axi_req,
  output svmc_axi_rsp_t axi_rsp,
  input svmc_rst_src_t rst_src,
  input logic monitor0_autostart,
  input logic [2:0] supply_above,
  input logic slow_tick,
  output logic [2:0] mon_reset_req,
  output logic [1:0] mon_irq,
  output logic sys_halt
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    svmc_wr_t wr;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_strb0;
    svmc_axi_rsp_t rsp;
    logic [7:0] den;
    logic [7:0] fsel;
    logic [7:0] lvl1;
    logic [7:0] mon0;
    logic [7:0] mon1;
    logic [7:0] mon2;
    logic [7:0] prot;
    logic cold_warm;
    logic osc_flag;
    logic halt;
    logic [2:0] rst_req;
    logic [1:0] irq;
  } svmc_top_st_t;

  // power applied counts as a power-on reset with detector 0 on
  localparam svmc_top_st_t ST_RESET = '{
    wr: WR_IDLE, den: DEN_RST_ON, fsel: FSEL_RST, lvl1: LVL1_RST,
    mon0: MON0_RST_ON, mon1: MON12_RST, mon2: MON12_RST, default: '0};

  svmc_top_st_t q;
  svmc_top_st_t d;

  logic [2:0] det_en;
  logic [2:0] det_act;
  logic [2:0] det_lvl;
  logic [2:0] det_rise;
  logic [2:0] det_fall;
  logic [7:0] ctl [3];
  logic master_en;
  logic [7:0] lvl1_view;
  logic [7:0] lvl2_view;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_byte;
  logic wr_cmt;
  logic wr_ok;
  logic full_rst;
  logic hw_rst;
  logic [1:0] evt;
  logic [1:0] chg;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic [IDX_W-1:0] to_idx(input logic [ADDR_W-1:0] a);
    to_idx = a[ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] i);
    case (i)
      IDX_LEVEL2_FLAG, IDX_DET_ENABLE, IDX_FUNC_SEL, IDX_LEVEL1_SEL,
      IDX_MON0_CTL, IDX_MON1_CTL, IDX_MON2_CTL, IDX_RESET_FLAGS, IDX_PROTECT:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // detectors
  // ------------------------------------------------------------
  assign master_en = q.fsel[BIT_MASTER_EN];
  assign det_en[0] = q.den[BIT_DET0_EN]; // [R18]
  assign det_en[1] = master_en & q.den[BIT_DET1_EN]; // [R19]
  assign det_en[2] = master_en & q.den[BIT_DET2_EN]; // [R20]
  assign ctl[0] = q.mon0;
  assign ctl[1] = q.mon1;
  assign ctl[2] = q.mon2;

  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_det
      svmc_det #(
        .EN_DLY_TICKS(EN_DLY_TICKS)
      ) u_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(det_en[g]),
        .above(supply_above[g]),
        .slow_tick(slow_tick),
        .div_sel(ctl[g][BIT_CTL_DIV_LO+1:BIT_CTL_DIV_LO]),
        .filt_dis(ctl[g][BIT_CTL_FILT_DIS]),
        .active(det_act[g]),
        .level(det_lvl[g]),
        .rise(det_rise[g]),
        .fall(det_fall[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // register views
  // ------------------------------------------------------------
  // stored value survives while the master enable is off
  assign lvl1_view = master_en ? q.lvl1 : LVL1_MASKED; // [R22]
  // detector level idles at 1 while disabled
  assign lvl2_view = 8'(det_lvl[2]) << BIT_LEVEL2_FLAG; // [R16]

  always_comb
  begin
    rd_idx = to_idx(axi_req.araddr);
    case (rd_idx)
      IDX_LEVEL2_FLAG: rd_byte = lvl2_view;
      IDX_DET_ENABLE: rd_byte = q.den;
      IDX_FUNC_SEL: rd_byte = q.fsel;
      IDX_LEVEL1_SEL: rd_byte = lvl1_view;
      IDX_MON0_CTL: rd_byte = q.mon0;
      IDX_MON1_CTL: rd_byte = q.mon1 | (8'(det_lvl[1]) << BIT_CTL_MON);
      IDX_MON2_CTL: rd_byte = q.mon2 | (8'(det_lvl[2]) << BIT_CTL_MON);
      IDX_RESET_FLAGS: rd_byte = (8'(q.cold_warm) << BIT_COLD_WARM) | (8'(q.osc_flag) << BIT_OSC_STOP);
      IDX_PROTECT: rd_byte = q.prot;
      default: rd_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    wr_cmt = 1'b0;
    wr_idx = to_idx(q.aw_addr);
    wr_ok = q.w_strb0 & q.prot[BIT_PROTECT3];
    full_rst = rst_src.por | rst_src.vm0;
    hw_rst = rst_src.hw;
    evt = 2'h0;
    chg = 2'h0;

    // write channel: address and data taken in either order
    if (axi_req.awvalid && q.rsp.awready)
    begin
      d.aw_have = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready)
    begin
      d.w_have = 1'b1;
      d.w_data = axi_req.wdata[7:0];
      d.w_strb0 = axi_req.wstrb[0];
    end
    case (q.wr)
      WR_IDLE:
        if (q.aw_have && q.w_have)
        begin
          wr_cmt = 1'b1;
          d.aw_have = 1'b0;
          d.w_have = 1'b0;
          d.rsp.bvalid = 1'b1;
          d.rsp.bresp = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
          d.wr = WR_RESP;
        end
      WR_RESP:
        if (axi_req.bready)
        begin
          d.rsp.bvalid = 1'b0;
          d.wr = WR_IDLE;
        end
      default:
        d.wr = WR_IDLE;
    endcase
    d.rsp.awready = ~d.aw_have & (d.wr == WR_IDLE);
    d.rsp.wready = ~d.w_have & (d.wr == WR_IDLE);

    // read channel: one outstanding read, data registered
    if (q.rsp.rvalid && axi_req.rready)
    begin
      d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.rsp.arready)
    begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = DATA_W'(rd_byte);
      d.rsp.rresp = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    d.rsp.arready = ~d.rsp.rvalid;

    // register writes
    if (wr_cmt)
    begin
      case (wr_idx)
        IDX_DET_ENABLE: if (wr_ok) d.den = q.w_data; // [R17]
        IDX_FUNC_SEL: if (wr_ok) d.fsel = q.w_data; // [R17]
        IDX_LEVEL1_SEL: if (wr_ok) d.lvl1 = q.w_data; // [R17]
        IDX_MON0_CTL: if (wr_ok) d.mon0 = q.w_data & MON0_WR_MASK;
        IDX_MON1_CTL:
          if (wr_ok) d.mon1 = (q.w_data & MON12_WR_MASK) | (q.mon1 & q.w_data & CHG_MASK);
        IDX_MON2_CTL:
          if (wr_ok) d.mon2 = (q.w_data & MON12_WR_MASK) | (q.mon2 & q.w_data & CHG_MASK);
        IDX_RESET_FLAGS:
          if (q.w_strb0 && q.w_data[BIT_COLD_WARM]) d.cold_warm = 1'b1; // [R3]
        IDX_PROTECT: if (q.w_strb0) d.prot = q.w_data;
        default: d.prot = q.prot;
      endcase
    end

    // detector events: reset requests, interrupts, change flags
    d.rst_req[0] = det_act[0] & ~det_lvl[0] & q.mon0[BIT_CTL_EN]; // [R9]
    for (int i = 1; i < 3; i++)
    begin
      if (ctl[i][BIT_CTL_MODE_RST])
      begin
        evt[i-1] = det_fall[i]; // [R10]
      end
      else if (ctl[i][BIT_CTL_FILT_DIS])
      begin
        evt[i-1] = ctl[i][BIT_CTL_FALL_SEL] ? det_fall[i] : det_rise[i]; // [R11]
      end
      else
      begin
        evt[i-1] = det_rise[i] | det_fall[i]; // [R11] [R23]
      end
      chg[i-1] = evt[i-1] & det_en[i];
      d.rst_req[i] = evt[i-1] & ctl[i][BIT_CTL_EN] & ctl[i][BIT_CTL_MODE_RST]; // [R10]
      d.irq[i-1] = evt[i-1] & ctl[i][BIT_CTL_EN] & ~ctl[i][BIT_CTL_MODE_RST]; // [R11]
    end
    // change flags: hardware set wins over a software clear
    if (chg[0]) d.mon1 = d.mon1 | CHG_MASK;
    if (chg[1]) d.mon2 = d.mon2 | CHG_MASK;

    // reset sources; watchdog and software resets touch nothing here [R14]
    if (rst_src.vm1 || rst_src.vm2)
    begin
      d.fsel = FSEL_RST; // [R15]
      d.lvl1 = LVL1_RST; // [R15]
    end
    if (full_rst || hw_rst)
    begin
      if (hw_rst && !full_rst && monitor0_autostart)
      begin
        d.den = DEN_RST_OFF; // [R13]
        d.mon0 = MON0_RST_OFF; // [R13]
      end
      else
      begin
        d.den = DEN_RST_ON; // [R6] [R13]
        d.mon0 = MON0_RST_ON; // [R6] [R13]
      end
      d.fsel = FSEL_RST;
      d.lvl1 = LVL1_RST;
      d.mon1 = MON12_RST;
      d.mon2 = MON12_RST;
      d.prot = 8'h00;
      d.halt = 1'b0; // [R7]
    end
    if (full_rst)
    begin
      d.cold_warm = 1'b0; // [R2]
      d.osc_flag = 1'b0; // [R8]
    end
    // osc-stop sets after clears so a coincident event is kept
    if (rst_src.osc)
    begin
      d.osc_flag = 1'b1;
      d.halt = 1'b1; // [R7]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= ST_RESET; // [R1]
    end
    else
    begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign axi_rsp = q.rsp;
  assign mon_reset_req = q.rst_req;
  assign mon_irq = q.irq;
  assign sys_halt = q.halt;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_cold_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    rst_src.por || rst_src.vm0 |=> !q.cold_warm)
    else $error("cold/warm flag not cleared");
  a_cold_keep: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    !rst_src.por && !rst_src.vm0 && !(wr_cmt && wr_idx == IDX_RESET_FLAGS) |=> $stable(q.cold_warm))
    else $error("cold/warm flag changed without a software write");
  a_halt_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    rst_src.osc |=> sys_halt)
    else $error("halt not raised by oscillation stop");
  a_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    sys_halt && !rst_src.hw && !rst_src.vm0 && !rst_src.por |=> sys_halt)
    else $error("halt released by wrong reset");
  a_osc_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    rst_src.hw && !rst_src.vm0 && !rst_src.por && !rst_src.osc |=> q.osc_flag == $past(q.osc_flag))
    else $error("osc-stop flag changed by hardware reset");
  a_den_guard: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
    wr_cmt && wr_idx == IDX_DET_ENABLE && !q.prot[BIT_PROTECT3] && rst_src == '0 |=> $stable(q.den))
    else $error("protected write was taken");
  a_lvl1_mask: assert property (@(posedge aclk) disable iff (!aresetn) // [R22]
    axi_req.arvalid && q.rsp.arready && rd_idx == IDX_LEVEL1_SEL && !master_en
    |=> axi_rsp.rvalid && axi_rsp.rdata[7:0] == LVL1_MASKED)
    else $error("level-1 select not masked");
  a_lvl2_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    !det_en[2] |=> ##1 lvl2_view[BIT_LEVEL2_FLAG])
    else $error("level-2 flag low while detector off");
  a_det0_rst: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    det_act[0] && !det_lvl[0] && q.mon0[BIT_CTL_EN] |=> mon_reset_req[0])
    else $error("detector 0 reset missing");
  a_irq_both: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    q.mon1[BIT_CTL_EN] && !q.mon1[BIT_CTL_MODE_RST] && !q.mon1[BIT_CTL_FILT_DIS] && det_rise[1]
    |=> mon_irq[0])
    else $error("filtered rising crossing gave no interrupt");
  a_autostart: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    rst_src.hw && !rst_src.por && !rst_src.vm0 && monitor0_autostart |=> !q.den[BIT_DET0_EN])
    else $error("detector 0 enabled despite autostart option");

endmodule

// ==== rtl/svmc_pkg.sv ====
package svmc_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_LEVEL2_FLAG = 6'h19;
  localparam logic [IDX_W-1:0] IDX_DET_ENABLE = 6'h1A;
  localparam logic [IDX_W-1:0] IDX_FUNC_SEL = 6'h26;
  localparam logic [IDX_W-1:0] IDX_LEVEL1_SEL = 6'h28;
  localparam logic [IDX_W-1:0] IDX_MON0_CTL = 6'h2A;
  localparam logic [IDX_W-1:0] IDX_MON1_CTL = 6'h2B;
  localparam logic [IDX_W-1:0] IDX_MON2_CTL = 6'h2C;
  localparam logic [IDX_W-1:0] IDX_RESET_FLAGS = 6'h30;
  localparam logic [IDX_W-1:0] IDX_PROTECT = 6'h31;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_LEVEL2_FLAG = 3;
  localparam int BIT_DET0_EN = 5;
  localparam int BIT_DET1_EN = 6;
  localparam int BIT_DET2_EN = 7;
  localparam int BIT_MASTER_EN = 7;
  localparam int BIT_PROTECT3 = 3;
  localparam int BIT_COLD_WARM = 0;
  localparam int BIT_OSC_STOP = 1;
  localparam int BIT_CTL_EN = 0;
  localparam int BIT_CTL_FILT_DIS = 1;
  localparam int BIT_CTL_CHG = 2;
  localparam int BIT_CTL_MON = 3;
  localparam int BIT_CTL_DIV_LO = 4;
  localparam int BIT_CTL_MODE_RST = 6;
  localparam int BIT_CTL_FALL_SEL = 7;

  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] DEN_RST_ON = 8'h20;
  localparam logic [7:0] DEN_RST_OFF = 8'h00;
  localparam logic [7:0] MON0_RST_ON = 8'hCB;
  localparam logic [7:0] MON0_RST_OFF = 8'hCA;
  localparam logic [7:0] MON12_RST = 8'h82;
  localparam logic [7:0] FSEL_RST = 8'h00;
  localparam logic [7:0] LVL1_RST = 8'h0A;
  localparam logic [7:0] LVL1_MASKED = 8'h0A;
  localparam logic [7:0] MON0_WR_MASK = 8'hFB;
  localparam logic [7:0] MON12_WR_MASK = 8'hF3;
  localparam logic [7:0] CHG_MASK = 8'h04;

  // ------------------------------------------------------------
  // timing: slow oscillator ticks
  // ------------------------------------------------------------
  localparam int FILT_SAMPLES = 3;
  localparam logic [7:0] EN_DLY_TICKS_DEF = 8'h14;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } svmc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } svmc_axi_rsp_t;

  typedef struct packed {
    logic por;
    logic hw;
    logic vm0;
    logic vm1;
    logic vm2;
    logic osc;
    logic wdt;
    logic sw;
  } svmc_rst_src_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } svmc_wr_t;

  typedef struct packed {
    logic [7:0] dly;
    logic active;
    logic [2:0] div;
    logic [FILT_SAMPLES-2:0] hist;
    logic level;
    logic rise;
    logic fall;
  } svmc_det_st_t;

endpackage

// ==== rtl/svmc_det.sv ====
`timescale 1ns/1ps
module svmc_det
  import svmc_pkg::*;
#(
  parameter logic [7:0] EN_DLY_TICKS = EN_DLY_TICKS_DEF
)
(
  input logic aclk,
  input logic aresetn,
  input logic enable,
  input logic above,
  input logic slow_tick,
  input logic [1:0] div_sel,
  input logic filt_dis,
  output logic active,
  output logic level,
  output logic rise,
  output logic fall
);

  svmc_det_st_t q;
  svmc_det_st_t d;
  logic nxt;

  function automatic logic [2:0] div_last(input logic [1:0] sel);
    case (sel)
      2'h0: div_last = 3'h0;
      2'h1: div_last = 3'h1;
      2'h2: div_last = 3'h3;
      default: div_last = 3'h7;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    nxt = q.level;
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (!enable)
    begin
      d = '0;
      d.level = 1'b1;
    end
    else if (!q.active)
    begin
      // crossings masked while the analog side settles
      if (slow_tick)
      begin
        if (q.dly == EN_DLY_TICKS - 8'h01)
        begin
          d.active = 1'b1; // [R18] [R19] [R20] [R24]
          d.level = above;
          d.hist = {(FILT_SAMPLES-1){above}};
        end
        else
        begin
          d.dly = q.dly + 8'h01;
        end
      end
    end
    else
    begin
      if (filt_dis)
      begin
        nxt = above;
      end
      else if (slow_tick)
      begin
        if (q.div == div_last(div_sel)) // [R12]
        begin
          d.div = 3'h0;
          d.hist = {q.hist[FILT_SAMPLES-3:0], above};
          if (q.hist == {(FILT_SAMPLES-1){above}})
          begin
            nxt = above; // [R12] [R23]
          end
        end
        else
        begin
          d.div = q.div + 3'h1;
        end
      end
      d.level = nxt;
      d.rise = nxt & ~q.level;
      d.fall = ~nxt & q.level;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '{default: '0, level: 1'b1};
    end
    else
    begin
      q <= d;
    end
  end

  assign active = q.active;
  assign level = q.level;
  assign rise = q.rise;
  assign fall = q.fall;

  a_dly_mask: assert property (@(posedge aclk) disable iff (!aresetn) !q.active |=> !q.rise && !q.fall) // [R24]
    else $error("crossing seen before detector active");
  a_off_idle: assert property (@(posedge aclk) disable iff (!aresetn) !enable |=> !q.active && q.level) // [R19]
    else $error("disabled detector still active");
  a_start_time: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    enable && !q.active && slow_tick && q.dly == EN_DLY_TICKS - 8'h01 |=> q.active)
    else $error("detector did not start after delay");

endmodule

// ==== dv/svmc_top_tb.sv ====
`timescale 1ns/1ps
module svmc_top_tb
  import svmc_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic slow_tick = 1'b0;
  logic autostart = 1'b0;
  logic [1:0] tcnt = 2'h0;
  svmc_axi_req_t req = '0;
  svmc_axi_rsp_t rsp;
  svmc_rst_src_t src = '0;
  logic [2:0] above = 3'h7;
  logic [2:0] mrr;
  logic [1:0] irq;
  logic halt;
  int n_i1 = 0;
  int n_r2 = 0;
  int n_r1 = 0;
  int n_i2 = 0;
  int bad_count = 0;
  int cmp_count = 0;

  always #20 aclk = ~aclk;

  // free-running tick, so the filter divider sees real spacing
  always @(posedge aclk)
  begin
    tcnt <= tcnt + 2'h1;
    slow_tick <= (tcnt == 2'h3);
    n_i1 <= n_i1 + int'(irq[0]);
    n_r2 <= n_r2 + int'(mrr[2]);
    n_r1 <= n_r1 + int'(mrr[1]);
    n_i2 <= n_i2 + int'(irq[1]);
  end

  svmc_top #(.EN_DLY_TICKS(8'h02)) i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .rst_src(src), .monitor0_autostart(autostart), .supply_above(above), .slow_tick(slow_tick),
    .mon_reset_req(mrr), .mon_irq(irq), .sys_halt(halt));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] ad(input logic [IDX_W-1:0] i);
    return {i, 2'b00};
  endfunction

  function automatic logic [7:0] lvl1_exp(input logic master, input logic [7:0] v);
    return master ? v : LVL1_MASKED;
  endfunction

  function automatic int irq_exp(input logic fd, input logic fs, input logic falling);
    return (!fd || (fs == falling)) ? 1 : 0;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // waits are bounded only by the watchdog
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready)
      begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready)
      begin
        w = 1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic cr(input logic [IDX_W-1:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(ad(i), d, r);
    chk($sformatf("reg %h", i), {24'h0, e}, d);
  endtask

  task automatic pulse(input svmc_rst_src_t s);
    src <= s;
    @(posedge aclk);
    src <= '0;
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #(40 * 30000);
    bad_count++;
    finish_test();
  end

  initial
  begin
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] v;
    logic fd;
    logic fs;
    logic [1:0] dv;
    int n;
    void'($urandom(71824));
    repeat (12) @(posedge aclk);
    // power-on and monitor-0 resets in use: high threshold-0 level assumed
    aresetn <= 1'b1;
    cr(IDX_DET_ENABLE, DEN_RST_ON);
    cr(IDX_MON0_CTL, MON0_RST_ON);
    cr(IDX_FUNC_SEL, FSEL_RST);
    cr(IDX_LEVEL1_SEL, LVL1_RST);
    cr(IDX_MON1_CTL, MON12_RST | (8'h01 << BIT_CTL_MON));
    cr(IDX_MON2_CTL, MON12_RST | (8'h01 << BIT_CTL_MON));
    cr(IDX_LEVEL2_FLAG, 8'h08);
    cr(IDX_RESET_FLAGS, 8'h00);
    rd(ad(6'h3F), d, r);
    chk("unmapped rd", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    wr(ad(6'h3F), 8'hFF, r);
    chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(ad(IDX_FUNC_SEL), 8'h80, r);
    cr(IDX_FUNC_SEL, FSEL_RST);
    wr(ad(IDX_PROTECT), 8'h08, r);
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom);
      wr(ad(IDX_FUNC_SEL), 8'h80, r);
      wr(ad(IDX_LEVEL1_SEL), v, r);
      cr(IDX_LEVEL1_SEL, lvl1_exp(1'b1, v));
      wr(ad(IDX_FUNC_SEL), 8'h00, r);
      cr(IDX_LEVEL1_SEL, lvl1_exp(1'b0, v));
    end
    wr(ad(IDX_FUNC_SEL), 8'h80, r);
    cr(IDX_LEVEL1_SEL, lvl1_exp(1'b1, v));
    // detectors on; delay is two ticks here
    wr(ad(IDX_DET_ENABLE), 8'hE0, r);
    wt(40);
    for (int k = 0; k < 4; k++)
    begin
      fd = (k < 2);
      fs = 1'($urandom);
      dv = 2'($urandom);
      wr(ad(IDX_MON1_CTL), {fs, 1'b0, dv, 2'b00, fd, 1'b1}, r);
      n = n_i1;
      above[1] <= 1'b0;
      wt(150);
      chk("irq fall", n + irq_exp(fd, fs, 1'b1), n_i1);
      n = n_i1;
      above[1] <= 1'b1;
      wt(150);
      chk("irq rise", n + irq_exp(fd, fs, 1'b0), n_i1);
    end
    wr(ad(IDX_MON1_CTL), 8'hC3, r);
    wr(ad(IDX_MON2_CTL), 8'hC3, r);
    wt(20);
    cr(IDX_LEVEL2_FLAG, 8'h08);
    n = n_r2;
    above[2] <= 1'b0;
    above[1] <= 1'b0;
    wt(40);
    chk("reset req 2", n + 1, n_r2);
    chk("reset req 1", 32'h1, n_r1);
    cr(IDX_LEVEL2_FLAG, 8'h00);
    above[1] <= 1'b1;
    wr(ad(IDX_MON2_CTL), 8'h01, r);
    n = n_i2;
    above[2] <= 1'b1;
    wt(150);
    chk("irq 2 rise", n + 1, n_i2);
    above[0] <= 1'b0;
    wt(40);
    chk("reset req 0", 32'h1, {31'h0, mrr[0]});
    above[0] <= 1'b1;
    wt(40);
    chk("reset rel 0", 32'h0, {31'h0, mrr[0]});
    // reset sources
    wr(ad(IDX_RESET_FLAGS), 8'h01, r);
    pulse(8'h02);
    pulse(8'h01);
    cr(IDX_FUNC_SEL, 8'h80);
    pulse(8'h10);
    cr(IDX_DET_ENABLE, 8'hE0);
    cr(IDX_RESET_FLAGS, 8'h01);
    pulse(8'h04);
    chk("halt set", 32'h1, {31'h0, halt});
    cr(IDX_RESET_FLAGS, 8'h03);
    autostart <= 1'b1;
    pulse(8'h40);
    chk("halt hw", 32'h0, {31'h0, halt});
    cr(IDX_RESET_FLAGS, 8'h03);
    cr(IDX_DET_ENABLE, DEN_RST_OFF);
    wr(ad(IDX_DET_ENABLE), 8'hE0, r);
    cr(IDX_DET_ENABLE, DEN_RST_OFF);
    cr(IDX_MON0_CTL, MON0_RST_OFF);
    pulse(8'h20);
    cr(IDX_RESET_FLAGS, 8'h00);
    cr(IDX_DET_ENABLE, DEN_RST_ON);
    cr(IDX_MON0_CTL, MON0_RST_ON);
    autostart <= 1'b0;
    pulse(8'h40);
    cr(IDX_DET_ENABLE, DEN_RST_ON);
    cr(IDX_RESET_FLAGS, 8'h00);
    finish_test();
  end
endmodule
